// File: mul_neg_exec_unit.sv
/*
 * multiply / negate execution unit with an ahb-lite register slave.
 * assumes the decode stage offers one instruction word at phase q1, that the data memory
 * returns the addressed byte while mem_rd_o is high (sampled at the end of q3), and that
 * acc_i holds the accumulator throughout the instruction cycle.
 */
`timescale 1ns/1ps
module mul_neg_exec_unit #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic instr_valid_i,
    input wire logic [15:0] instr_i,
    input wire logic [7:0] acc_i,
    input wire logic [ADDR_W-1:0] index_base_i,
    input wire logic [7:0] mem_rdata_i,
    output logic [ADDR_W-1:0] mem_addr_o,
    output logic mem_rd_o,
    output logic mem_wr_o,
    output logic [7:0] mem_wdata_o,
    output logic [7:0] product_high_byte_o,
    output logic [7:0] product_low_byte_o,
    output logic [4:0] status_flags_o,
    output logic [1:0] phase_o,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o
);
    mul_neg_exec_pkg::phase_t phase_q;
    mul_neg_exec_pkg::op_t op_q;
    logic [7:0] lit_q;
    logic [15:0] prod_res_q;
    logic [4:0] flag_res_q;
    logic commit_prod_q;
    logic commit_flag_q;
    logic ext_en_q;
    logic [3:0] bank_select_register_q;
    logic [15:0] prod_q;
    logic [4:0] flags_q;
    logic bus_wr_q;
    logic [7:0] bus_addr_q;
    logic bus_req;
    logic sw_wr;
    logic [7:0] operand;
    logic [7:0] neg_val;

    function automatic mul_neg_exec_pkg::op_t decode_op(input logic [15:0] w);
        if (w[15:8] == mul_neg_exec_pkg::OPC_MUL_IMM)
            return mul_neg_exec_pkg::OP_MUL_IMM;
        else if (w[15:9] == mul_neg_exec_pkg::OPC_MUL_REG)
            return mul_neg_exec_pkg::OP_MUL_REG;
        else if (w[15:9] == mul_neg_exec_pkg::OPC_NEG_REG)
            return mul_neg_exec_pkg::OP_NEG_REG;
        return mul_neg_exec_pkg::OP_NONE;
    endfunction : decode_op

    // bit 8 of the word is the access-select bit, low byte the file address
    function automatic logic [ADDR_W-1:0] eff_addr(input logic [15:0] w, input logic ext,
                                                   input logic [3:0] bank, input logic [ADDR_W-1:0] idx);
        logic [ADDR_W-1:0] a;
        a = '0;
        if (w[8])
            a = ADDR_W'({bank, w[7:0]});
        else if (ext && w[7:0] <= mul_neg_exec_pkg::INDEXED_MAX_F)
            a = ADDR_W'(idx + ADDR_W'(w[7:0]));
        else if (w[7:0] >= mul_neg_exec_pkg::ACCESS_SPLIT_F)
            a = ADDR_W'({mul_neg_exec_pkg::ACCESS_HIGH_BANK, w[7:0]});
        else
            a = ADDR_W'({mul_neg_exec_pkg::ACCESS_LOW_BANK, w[7:0]});
        return a;
    endfunction : eff_addr

    function automatic logic [31:0] read_mux(input logic [7:0] ofs, input logic ext, input logic [3:0] bank,
                                             input logic [15:0] prod, input logic [4:0] flags);
        case (ofs)
            mul_neg_exec_pkg::OFS_CTRL: return {31'h0, ext};
            mul_neg_exec_pkg::OFS_BANK: return {28'h0, bank};
            mul_neg_exec_pkg::OFS_PROD_LO: return {24'h0, prod[7:0]};
            mul_neg_exec_pkg::OFS_PROD_HI: return {24'h0, prod[15:8]};
            mul_neg_exec_pkg::OFS_STATUS: return {27'h0, flags};
            default: return 32'h0;
        endcase
    endfunction : read_mux

    // flags of the negate, built from the operand: ~d + 1 carries out of bit 3 only when the
    // low nibble is zero, and out of bit 7 only when the whole byte is zero
    function automatic logic [4:0] neg_flags(input logic [7:0] d);
        logic [4:0] f;
        logic [7:0] r;
        f = '0;
        r = 8'h00 - d;
        f[mul_neg_exec_pkg::FLAG_N] = r[7];
        f[mul_neg_exec_pkg::FLAG_OV] = d == 8'h80;
        f[mul_neg_exec_pkg::FLAG_C] = d == 8'h00;
        f[mul_neg_exec_pkg::FLAG_DC] = d[3:0] == 4'h0;
        f[mul_neg_exec_pkg::FLAG_Z] = r == 8'h00;
        return f;
    endfunction : neg_flags

    // only the register-operand forms touch the data memory
    function automatic logic reads_file(input mul_neg_exec_pkg::op_t op);
        return op == mul_neg_exec_pkg::OP_MUL_REG || op == mul_neg_exec_pkg::OP_NEG_REG;
    endfunction : reads_file

    // both multiplies commit the product pair and nothing else
    function automatic logic is_multiply(input mul_neg_exec_pkg::op_t op);
        return op == mul_neg_exec_pkg::OP_MUL_IMM || op == mul_neg_exec_pkg::OP_MUL_REG;
    endfunction : is_multiply

    assign bus_req = hsel_i && hready_i && htrans_i[1];
    assign sw_wr = bus_wr_q;
    assign operand = (op_q == mul_neg_exec_pkg::OP_MUL_IMM) ? lit_q : mem_rdata_i;
    assign neg_val = 8'h00 - mem_rdata_i;

    // four phases per instruction cycle, free running
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            phase_q <= mul_neg_exec_pkg::PH_Q1;
        else if (ce_i)
        begin
            case (phase_q)
                mul_neg_exec_pkg::PH_Q1: phase_q <= mul_neg_exec_pkg::PH_Q2;
                mul_neg_exec_pkg::PH_Q2: phase_q <= mul_neg_exec_pkg::PH_Q3;
                mul_neg_exec_pkg::PH_Q3: phase_q <= mul_neg_exec_pkg::PH_Q4;
                default: phase_q <= mul_neg_exec_pkg::PH_Q1;
            endcase
        end
    end

    // q1: decode and address the operand
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            op_q <= mul_neg_exec_pkg::OP_NONE;
            lit_q <= 8'h00;
            mem_addr_o <= '0;
            mem_rd_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (phase_q == mul_neg_exec_pkg::PH_Q1)
            begin
                op_q <= instr_valid_i ? decode_op(instr_i) : mul_neg_exec_pkg::OP_NONE;
                lit_q <= instr_i[7:0];
                mem_addr_o <= eff_addr(instr_i, ext_en_q, bank_select_register_q, index_base_i);
                mem_rd_o <= instr_valid_i && reads_file(decode_op(instr_i));
            end
            else if (phase_q == mul_neg_exec_pkg::PH_Q3)
                mem_rd_o <= 1'b0;
        end
    end

    // q3: sample operands and process
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            prod_res_q <= 16'h0000;
            flag_res_q <= 5'h00;
            commit_prod_q <= 1'b0;
            commit_flag_q <= 1'b0;
            mem_wdata_o <= 8'h00;
            mem_wr_o <= 1'b0;
        end
        else if (ce_i)
        begin
            if (phase_q == mul_neg_exec_pkg::PH_Q3)
            begin
                // unsigned 8x8, the accumulator is only read
                prod_res_q <= {8'h00, acc_i} * {8'h00, operand};
                commit_prod_q <= is_multiply(op_q);
                flag_res_q <= neg_flags(mem_rdata_i);
                // the negate is the only instruction that touches flags
                commit_flag_q <= op_q == mul_neg_exec_pkg::OP_NEG_REG;
                mem_wdata_o <= neg_val;
                mem_wr_o <= op_q == mul_neg_exec_pkg::OP_NEG_REG;
            end
            else if (phase_q == mul_neg_exec_pkg::PH_Q4)
            begin
                commit_prod_q <= 1'b0;
                commit_flag_q <= 1'b0;
                mem_wr_o <= 1'b0;
            end
        end
    end

    // q4 write of the product pair; the hardware write beats a same-cycle software write
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            prod_q <= mul_neg_exec_pkg::RST_PROD;
        else if (ce_i)
        begin
            if (phase_q == mul_neg_exec_pkg::PH_Q4 && commit_prod_q)
                prod_q <= prod_res_q;
            else if (sw_wr && bus_addr_q == mul_neg_exec_pkg::OFS_PROD_LO)
                prod_q[7:0] <= hwdata_i[7:0];
            else if (sw_wr && bus_addr_q == mul_neg_exec_pkg::OFS_PROD_HI)
                prod_q[15:8] <= hwdata_i[7:0];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            flags_q <= mul_neg_exec_pkg::RST_STATUS;
        else if (ce_i)
        begin
            if (phase_q == mul_neg_exec_pkg::PH_Q4 && commit_flag_q)
                flags_q <= flag_res_q;
            else if (sw_wr && bus_addr_q == mul_neg_exec_pkg::OFS_STATUS)
                flags_q <= hwdata_i[4:0];
        end
    end

    // extended instruction set enable, written by software only
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            ext_en_q <= mul_neg_exec_pkg::RST_CTRL[0];
        else if (ce_i && sw_wr && bus_addr_q == mul_neg_exec_pkg::OFS_CTRL)
            ext_en_q <= hwdata_i[mul_neg_exec_pkg::CTRL_EXT_EN];
    end

    // bank select; a change takes effect at the next q1, never mid instruction
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
            bank_select_register_q <= mul_neg_exec_pkg::RST_BANK;
        else if (ce_i && sw_wr && bus_addr_q == mul_neg_exec_pkg::OFS_BANK)
            bank_select_register_q <= hwdata_i[3:0];
    end

    // zero-wait slave: reads are prepared in the address phase so hrdata is a flop
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            bus_wr_q <= 1'b0;
            bus_addr_q <= 8'h00;
            hrdata_o <= 32'h0;
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
        end
        else if (ce_i)
        begin
            bus_wr_q <= bus_req && hwrite_i;
            bus_addr_q <= {haddr_i[7:2], 2'b00};
            hreadyout_o <= 1'b1;
            hresp_o <= 1'b0;
            if (bus_req && !hwrite_i)
                hrdata_o <= read_mux({haddr_i[7:2], 2'b00}, ext_en_q, bank_select_register_q, prod_q, flags_q);
            else
                hrdata_o <= 32'h0;
        end
    end

    // outputs are registered copies, one clock behind the state they show
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            product_high_byte_o <= mul_neg_exec_pkg::RST_PROD[15:8];
            product_low_byte_o <= mul_neg_exec_pkg::RST_PROD[7:0];
        end
        else if (ce_i)
        begin
            product_high_byte_o <= prod_q[15:8];
            product_low_byte_o <= prod_q[7:0];
        end
    end

    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            status_flags_o <= mul_neg_exec_pkg::RST_STATUS;
            phase_o <= 2'h0;
        end
        else if (ce_i)
        begin
            status_flags_o <= flags_q;
            phase_o <= phase_q;
        end
    end
endmodule : mul_neg_exec_unit

// File: mul_neg_exec_pkg.sv
/*
 * constants for the multiply / negate execution unit: opcodes, addressing limits,
 * flag positions, register offsets and reset values.
 * assumes nothing beyond a systemverilog tool.
 */
package mul_neg_exec_pkg;
    localparam logic [7:0] OPC_MUL_IMM = 8'h0d;
    localparam logic [6:0] OPC_MUL_REG = 7'h01;
    localparam logic [6:0] OPC_NEG_REG = 7'h36;
    localparam logic [7:0] INDEXED_MAX_F = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT_F = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam int CTRL_EXT_EN = 0;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_BANK = 8'h04;
    localparam logic [7:0] OFS_PROD_LO = 8'h08;
    localparam logic [7:0] OFS_PROD_HI = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [0:0] RST_CTRL = 1'h0;
    localparam logic [3:0] RST_BANK = 4'h0;
    localparam logic [15:0] RST_PROD = 16'h0000;
    localparam logic [4:0] RST_STATUS = 5'h00;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} phase_t;
    typedef enum logic [1:0] {OP_NONE, OP_MUL_IMM, OP_MUL_REG, OP_NEG_REG} op_t;
endpackage : mul_neg_exec_pkg

// File: mul_neg_exec_unit_asserts.sv
/* checker for the multiply / negate unit: memory strobes, negate result and flags,
   product commit, phase order. assumes one clock domain; checking pauses while ce_i is low,
   as the unit itself does. */
`timescale 1ns/1ps
module mul_neg_exec_unit_asserts #(
    parameter int ADDR_W = 12
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] mem_rdata_i,
    input wire logic [ADDR_W-1:0] mem_addr_o,
    input wire logic mem_rd_o,
    input wire logic mem_wr_o,
    input wire logic [7:0] mem_wdata_o,
    input wire logic [7:0] product_high_byte_o,
    input wire logic [7:0] product_low_byte_o,
    input wire logic [4:0] status_flags_o,
    input wire logic [1:0] phase_o
);
    logic [7:0] res_q;
    // last negate result, so the flags can be judged one cycle after the strobe ends
    always_ff @(posedge sys_clk_i)
    begin
        if (mem_wr_o)
            res_q <= mem_wdata_o;
    end
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i || !ce_i);
    wr_single_a: assert property ($rose(mem_wr_o) |=> !mem_wr_o [*3])
        else $error("write strobe not a lone cycle");
    rd_two_a: assert property ($rose(mem_rd_o) |-> mem_rd_o [*2] ##1 !mem_rd_o)
        else $error("read strobe not two cycles");
    addr_hold_a: assert property ($past(mem_rd_o) |-> $stable(mem_addr_o))
        else $error("operand address moved mid cycle");
    wdata_neg_a: assert property ($rose(mem_wr_o) |-> mem_wdata_o == 8'h00 - $past(mem_rdata_i))
        else $error("written byte not the negated operand");
    flags_neg_a: assert property ($fell(mem_wr_o) |=> status_flags_o ==
        {res_q[7], res_q == 8'h80, res_q == 8'h00, res_q[3:0] == 4'h0, res_q == 8'h00})
        else $error("negate flags wrong");
    prod_reg_a: assert property ($fell(mem_rd_o) && !mem_wr_o |-> ##2
        {product_high_byte_o, product_low_byte_o} == 16'($past(acc_i, 3)) * 16'($past(mem_rdata_i, 3)))
        else $error("register product wrong");
    flags_kept_a: assert property ($fell(mem_rd_o) && !mem_wr_o |-> ##2
        status_flags_o == $past(status_flags_o, 3))
        else $error("multiply changed the flags");
    phase_step_a: assert property ($past(rst_n_i) && $past(rst_n_i, 2) && $past(ce_i) && $past(ce_i, 2)
        |-> phase_o == $past(phase_o) + 2'd1)
        else $error("phase did not advance");
endmodule : mul_neg_exec_unit_asserts
bind mul_neg_exec_unit mul_neg_exec_unit_asserts #(.ADDR_W(ADDR_W)) i_chk (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .acc_i(acc_i), .mem_rdata_i(mem_rdata_i),
    .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
    .product_high_byte_o(product_high_byte_o), .product_low_byte_o(product_low_byte_o),
    .status_flags_o(status_flags_o), .phase_o(phase_o)
);

// File: data_mem_model.sv
/* banked data memory beside the unit.
   assumes the read strobe stands while the addressed byte is wanted. */
`timescale 1ns/1ps
module data_mem_model (
    input wire logic sys_clk_i,
    input wire logic [11:0] addr_i,
    input wire logic rd_i,
    input wire logic wr_i,
    input wire logic [7:0] wdata_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem [4096];
    logic [7:0] last_q = 8'h00;
    // a released bus shows the inverse, so a late sample cannot pass by luck
    assign rdata_o = rd_i ? mem[addr_i] : ~last_q;
    always @(posedge sys_clk_i)
    begin
        if (rd_i)
            last_q <= mem[addr_i];
        if (wr_i)
            mem[addr_i] <= wdata_i;
    end
endmodule : data_mem_model

// File: mul_neg_exec_unit_tb.sv
/* self-checking bench for the multiply / negate unit.
   assumes the memory model beside it and the checker bound to the unit. */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module mul_neg_exec_unit_tb;
    localparam logic [6:0] MUL_REG = mul_neg_exec_pkg::OPC_MUL_REG;
    logic sys_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic ce_i = 1'b1;
    logic instr_valid_i = 1'b0;
    logic [15:0] instr_i = 16'h0000;
    logic [7:0] acc_i = 8'h00;
    logic [7:0] mem_rdata_i, mem_wdata_o, product_high_byte_o, product_low_byte_o;
    logic [11:0] mem_addr_o;
    logic mem_rd_o, mem_wr_o, hreadyout_o, hresp_o;
    logic hsel_i = 1'b0;
    logic hwrite_i = 1'b0;
    logic [1:0] phase_o;
    logic [1:0] htrans_i = 2'h0;
    logic [4:0] status_flags_o;
    logic [31:0] haddr_i = 32'h0;
    logic [31:0] hwdata_i = 32'h0;
    logic [31:0] hrdata_o, rd_q;
    int err_count = 0;
    int checks_done = 0;
    int cycles = 0;
    mul_neg_exec_unit i_dut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
        .instr_valid_i(instr_valid_i), .instr_i(instr_i), .acc_i(acc_i), .index_base_i(12'h300),
        .mem_rdata_i(mem_rdata_i), .mem_addr_o(mem_addr_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
        .mem_wdata_o(mem_wdata_o), .product_high_byte_o(product_high_byte_o),
        .product_low_byte_o(product_low_byte_o), .status_flags_o(status_flags_o), .phase_o(phase_o),
        .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
        .hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
        .hrdata_o(hrdata_o));
    data_mem_model i_mem (.sys_clk_i(sys_clk_i), .addr_i(mem_addr_o), .rd_i(mem_rd_o), .wr_i(mem_wr_o),
        .wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        hsel_i <= 1'b1;
        haddr_i <= {24'h0, a};
        hwrite_i <= w;
        htrans_i <= mul_neg_exec_pkg::HTRANS_NONSEQ;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        do @(posedge sys_clk_i); while (hreadyout_o !== 1'b1);
        rd_q = hrdata_o;
    endtask : bus
    // a stall drops the clock enable for that many cycles right after the q1 sampling edge;
    // the frozen check there expects a register-operand instruction
    task automatic exec(input logic [15:0] w, input logic [7:0] a, input int stall = 0);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        // phase_o shows q3 before the edge that enters q1, so the word stands at the q1 sampling edge
        while (phase_o !== 2'd2 && n < 8)
        begin
            @(posedge sys_clk_i);
            n++;
        end
        instr_i <= w;
        instr_valid_i <= 1'b1;
        acc_i <= a;
        @(posedge sys_clk_i);
        instr_valid_i <= 1'b0;
        if (stall > 0)
        begin
            ce_i <= 1'b0;
            repeat (stall) @(posedge sys_clk_i);
            `CHK({phase_o, mem_rd_o}, 3'h1)
            ce_i <= 1'b1;
        end
        repeat (7) @(posedge sys_clk_i);
        #1;
    endtask : exec
    function automatic logic [4:0] neg_flags(input logic [7:0] d);
        logic [7:0] r;
        r = 8'h00 - d;
        return {r[7], d == 8'h80, r == 8'h00, d[3:0] == 4'h0, d == 8'h00};
    endfunction : neg_flags
    task automatic t_neg;
        logic [7:0] v [4] = '{8'h3a, 8'h00, 8'h01, 8'h80};
        foreach (v[i])
        begin
            i_mem.mem[12'h020] = v[i];
            exec({mul_neg_exec_pkg::OPC_NEG_REG, 1'b0, 8'h20}, 8'h00);
            `CHK(i_mem.mem[12'h020], 8'h00 - v[i])
            `CHK(status_flags_o, neg_flags(v[i]))
        end
        $display("negate test done");
    endtask : t_neg
    task automatic t_mul_imm;
        logic [7:0] a [3] = '{8'h00, 8'he2, 8'hff};
        logic [7:0] k [3] = '{8'h37, 8'hc4, 8'hff};
        logic [4:0] f;
        f = status_flags_o;
        foreach (a[i])
        begin
            exec({mul_neg_exec_pkg::OPC_MUL_IMM, k[i]}, a[i]);
            `CHK({product_high_byte_o, product_low_byte_o}, 16'(a[i]) * 16'(k[i]))
            `CHK(status_flags_o, f)
        end
        exec(16'h0e05, 8'h33);
        `CHK({product_high_byte_o, product_low_byte_o}, 16'hfe01)
        bus(1'b0, mul_neg_exec_pkg::OFS_PROD_HI, 32'h0);
        `CHK(rd_q, 32'h000000fe)
        $display("multiply immediate test done");
    endtask : t_mul_imm
    task automatic t_mul_reg;
        logic [15:0] w [4] = '{{MUL_REG, 1'b1, 8'h10}, {MUL_REG, 1'b0, 8'h70}, {MUL_REG, 1'b0, 8'h20},
            {MUL_REG, 1'b0, 8'h60}};
        logic [11:0] ad [4] = '{12'h510, 12'hf70, 12'h320, 12'hf60};
        logic [7:0] d [4] = '{8'hb5, 8'h03, 8'h07, 8'h02};
        logic [7:0] a [4] = '{8'hc4, 8'h10, 8'h09, 8'h02};
        bus(1'b1, mul_neg_exec_pkg::OFS_BANK, 32'h5);
        bus(1'b0, mul_neg_exec_pkg::OFS_BANK, 32'h0);
        `CHK(rd_q[3:0], 4'h5)
        foreach (w[i])
        begin
            i_mem.mem[{4'h0, w[i][7:0]}] = 8'h55;
            i_mem.mem[ad[i]] = d[i];
            if (i == 2)
                bus(1'b1, mul_neg_exec_pkg::OFS_CTRL, 32'h1);
            exec(w[i], a[i]);
            `CHK({product_high_byte_o, product_low_byte_o}, 16'(a[i]) * 16'(d[i]))
            `CHK(i_mem.mem[ad[i]], d[i])
        end
        bus(1'b0, 8'h40, 32'h0);
        `CHK(rd_q, 32'h0)
        $display("multiply register test done");
    endtask : t_mul_reg
    task automatic t_freeze;
        bus(1'b1, mul_neg_exec_pkg::OFS_STATUS, 32'h15);
        bus(1'b0, mul_neg_exec_pkg::OFS_STATUS, 32'h0);
        `CHK(rd_q, 32'h00000015)
        i_mem.mem[12'h5a7] = 8'h0b;
        exec({MUL_REG, 1'b1, 8'ha7}, 8'h0d, 6);
        `CHK({product_high_byte_o, product_low_byte_o}, 16'h008f)
        `CHK(status_flags_o, 5'h15)
        $display("clock enable test done");
    endtask : t_freeze
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude
    always @(posedge sys_clk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_count++;
            conclude();
        end
    end
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        #1;
        `CHK({product_high_byte_o, product_low_byte_o, status_flags_o, hresp_o, hreadyout_o}, 23'h1)
        t_neg();
        t_mul_imm();
        t_mul_reg();
        t_freeze();
        conclude();
    end
endmodule : mul_neg_exec_unit_tb
